// *** logic/grf_pkg.sv ***
// package: constants and types of the cpu general register file
//
// Contract
// - banked group: four data, two address, frame base
// - two independent copies of the banked group
// - four 16-bit data registers, read and write
// - data zero/one bytes written separately, other kept
// - data two and zero pair into 32 bits; a long core write stores only the low word
// - address registers supply indirect/relative base
// - address registers also ordinary operands
// - address pair 32 bits, address one upper; a long core write stores only the low word
package grf_pkg;
    localparam int unsigned grf_word_w = 16;
    localparam int unsigned grf_byte_w = 8;
    localparam int unsigned grf_banks = 2;
    localparam int unsigned grf_regs = 7;
    localparam int unsigned grf_sel_w = 3;
    localparam int unsigned grf_mem_aw = 4;
    localparam logic [2:0] grf_idx_data_zero = 3'h0;
    localparam logic [2:0] grf_idx_data_one = 3'h1;
    localparam logic [2:0] grf_idx_data_two = 3'h2;
    localparam logic [2:0] grf_idx_data_three = 3'h3;
    localparam logic [2:0] grf_idx_addr_zero = 3'h4;
    localparam logic [2:0] grf_idx_addr_one = 3'h5;
    localparam logic [2:0] grf_idx_frame_base = 3'h6;
    localparam logic [15:0] grf_reset_word = 16'h0000;
    // apb map: byte addresses of software-visible views
    localparam logic [7:0] grf_apb_bank0 = 8'h00;
    localparam logic [7:0] grf_apb_bank1 = 8'h20;
    localparam logic [7:0] grf_apb_ctrl = 8'h40;
    localparam logic [7:0] grf_apb_data_pair = 8'h44;
    localparam logic [7:0] grf_apb_addr_pair = 8'h48;
    localparam logic [7:0] grf_apb_data1_pair = 8'h4C;
    localparam int unsigned grf_ctrl_bank_bit = 0;

    // width of a core access
    typedef enum logic [1:0] {
        grf_size_byte_type_e,
        grf_size_word_type_e,
        grf_size_long_type_e
    } grf_size_type;

    // memory port state
    typedef struct packed {
        logic [15:0] rdata_a;
        logic [15:0] rdata_b;
    } grf_mem_state_type;
endpackage

// *** logic/grf_mem_if.sv ***
// interface: write and dual read port of the banked word memory
interface grf_mem_if;
    logic we;
    logic [3:0] waddr;
    logic [15:0] wdata;
    logic [1:0] wbe;
    logic [3:0] raddr_a;
    logic [3:0] raddr_b;
    logic [15:0] rdata_a;
    logic [15:0] rdata_b;
    modport ctrl (output we, output waddr, output wdata, output wbe,
        output raddr_a, output raddr_b, input rdata_a, input rdata_b);
    modport mem (input we, input waddr, input wdata, input wbe,
        input raddr_a, input raddr_b, output rdata_a, output rdata_b);
endinterface

// *** logic/grf_mem.sv ***
// module: banked 16-bit word storage with byte enables and registered reads
module grf_mem (
    input wire logic sys_clk,
    input wire logic sys_rst,
    grf_mem_if.mem port
);
    localparam int unsigned depth = grf_pkg::grf_banks * (1 << grf_pkg::grf_sel_w);
    logic [15:0] store_q [depth];
    grf_pkg::grf_mem_state_type st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.rdata_a = store_q[port.raddr_a];
        st_d.rdata_b = store_q[port.raddr_b];
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // no reset on storage: contents are undefined after reset like the cpu's
    for (genvar i = 0; i < depth; i++) begin : g_word
        always_ff @(posedge sys_clk) begin
            if (port.we && port.waddr == 4'(i)) begin
                if (port.wbe[0]) begin
                    store_q[i][7:0] <= port.wdata[7:0];
                end
                if (port.wbe[1]) begin
                    store_q[i][15:8] <= port.wdata[15:8];
                end
            end
        end
    end

    assign port.rdata_a = st_q.rdata_a;
    assign port.rdata_b = st_q.rdata_b;
endmodule

// *** logic/grf_top.sv ***
// module: general register file with core ports and apb access
//
// The APB register port and the register offsets were left to the implementer.
module grf_top (
    input wire logic sys_clk,
    input wire logic sys_rst,
    // core write port
    input wire logic core_we,
    input wire logic [2:0] core_wsel,
    input wire logic [1:0] core_wsize,
    input wire logic core_whigh,
    input wire logic [31:0] core_wdata,
    // core read port
    input wire logic core_re,
    input wire logic [2:0] core_rsel,
    input wire logic [1:0] core_rsize,
    input wire logic core_rhigh,
    output logic core_rvalid,
    output logic [31:0] core_rdata,
    // address base for indirect and relative addressing
    input wire logic core_base_sel,
    input wire logic core_base_long,
    output logic [31:0] core_base,
    // bank select from the flag register
    input wire logic core_bank_set,
    input wire logic core_bank_val,
    output logic bank_sel,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef enum logic [2:0] {
        grf_idle_type_e,
        grf_core_rd_type_e,
        grf_base_rd_type_e,
        grf_apb_rd_type_e,
        grf_apb_wr2_type_e,
        grf_apb_done_type_e
    } grf_phase_type;

    typedef struct packed {
        grf_phase_type phase;
        logic bank;
        logic [1:0] rsize;
        logic rhigh;
        logic rlong;
        logic [15:0] hi_word;
        logic [2:0] hi_sel;
        logic hi_bank;
        logic [31:0] apb_wr;
        logic core_rvalid;
        logic [31:0] core_rdata;
        logic [31:0] core_base;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic err;
    } grf_state_type;

    grf_state_type st_q, st_d;
    grf_mem_if mif ();

    grf_mem u_mem (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .port(mif)
    );

    // memory word address: bank in bit 3, register index below
    function automatic logic [3:0] maddr(input logic bank, input logic [2:0] sel);
        maddr = {bank, sel};
    endfunction

    // the upper word of a 32-bit pair
    function automatic logic [2:0] pair_hi(input logic [2:0] sel);
        if (sel == grf_pkg::grf_idx_addr_zero) begin
            pair_hi = grf_pkg::grf_idx_addr_one;
        end else if (sel == grf_pkg::grf_idx_data_one) begin
            pair_hi = grf_pkg::grf_idx_data_three;
        end else begin
            pair_hi = grf_pkg::grf_idx_data_two;
        end
    endfunction

    logic apb_setup;
    logic [2:0] apb_idx;
    logic apb_bank;
    logic apb_in_file;

    always_comb begin
        apb_setup = psel && !penable;
        apb_idx = paddr[4:2];
        apb_bank = paddr[5];
        apb_in_file = (paddr[7:6] == 2'h0) && (apb_idx < grf_pkg::grf_regs[2:0]);
    end

    always_comb begin
        st_d = st_q;
        st_d.core_rvalid = 1'b0;
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        mif.we = 1'b0;
        mif.waddr = '0;
        mif.wdata = '0;
        mif.wbe = 2'h0;
        mif.raddr_a = '0;
        mif.raddr_b = '0;

        // bank switch only moves the view; storage is untouched
        if (core_bank_set) begin
            st_d.bank = core_bank_val;
        end

        // core writes have priority over apb writes on the single port
        if (core_we) begin
            mif.we = 1'b1;
            mif.waddr = maddr(st_q.bank, core_wsel);
            mif.wdata = core_wdata[15:0];
            mif.wbe = 2'h3;
            if (core_wsize == grf_pkg::grf_size_byte_type_e) begin
                mif.wdata = {core_wdata[7:0], core_wdata[7:0]};
                mif.wbe = core_whigh ? 2'h2 : 2'h1;
            end
        end

        case (st_q.phase)
            grf_idle_type_e: begin
                if (core_re) begin
                    mif.raddr_a = maddr(st_q.bank, core_rsel);
                    mif.raddr_b = maddr(st_q.bank, pair_hi(core_rsel));
                    st_d.rsize = core_rsize;
                    st_d.rhigh = core_rhigh;
                    st_d.phase = grf_core_rd_type_e;
                end else if (core_base_sel || core_base_long) begin
                    mif.raddr_a = maddr(st_q.bank,
                        core_base_sel ? grf_pkg::grf_idx_addr_one : grf_pkg::grf_idx_addr_zero);
                    mif.raddr_b = maddr(st_q.bank, grf_pkg::grf_idx_addr_one);
                    st_d.rlong = core_base_long;
                    st_d.phase = grf_base_rd_type_e;
                end else if (apb_setup) begin
                    mif.raddr_a = maddr(apb_bank, apb_idx);
                    // pair views follow the visible bank
                    mif.raddr_b = maddr(st_q.bank, pair_hi(paddr[3:2] == 2'h3 ?
                        grf_pkg::grf_idx_data_one : (paddr[3:2] == 2'h2 ?
                        grf_pkg::grf_idx_addr_zero : grf_pkg::grf_idx_data_zero)));
                    st_d.apb_wr = pwdata;
                    st_d.phase = grf_apb_rd_type_e;
                end
            end
            grf_core_rd_type_e: begin
                st_d.core_rvalid = 1'b1;
                case (st_q.rsize)
                    grf_pkg::grf_size_byte_type_e: st_d.core_rdata = {24'h000000,
                        st_q.rhigh ? mif.rdata_a[15:8] : mif.rdata_a[7:0]};
                    grf_pkg::grf_size_long_type_e:
                        st_d.core_rdata = {mif.rdata_b, mif.rdata_a};
                    default: st_d.core_rdata = {16'h0000, mif.rdata_a};
                endcase
                st_d.phase = grf_idle_type_e;
            end
            grf_base_rd_type_e: begin
                st_d.core_base = st_q.rlong ? {mif.rdata_b, mif.rdata_a}
                    : {16'h0000, mif.rdata_a};
                st_d.phase = grf_idle_type_e;
            end
            grf_apb_rd_type_e: begin
                st_d.err = 1'b0;
                if (paddr == grf_pkg::grf_apb_ctrl) begin
                    st_d.prdata = {31'h0, st_q.bank};
                    if (pwrite && !core_bank_set) begin
                        st_d.bank = st_q.apb_wr[grf_pkg::grf_ctrl_bank_bit];
                    end
                    st_d.phase = grf_apb_done_type_e;
                end else if (apb_in_file) begin
                    st_d.prdata = {16'h0000, mif.rdata_a};
                    st_d.hi_sel = apb_idx;
                    st_d.hi_bank = apb_bank;
                    st_d.phase = pwrite ? grf_apb_wr2_type_e : grf_apb_done_type_e;
                end else if (paddr == grf_pkg::grf_apb_data_pair ||
                        paddr == grf_pkg::grf_apb_addr_pair ||
                        paddr == grf_pkg::grf_apb_data1_pair) begin
                    // pairs are read from the visible bank
                    st_d.prdata = {mif.rdata_b, 16'h0000};
                    st_d.hi_word = mif.rdata_b;
                    st_d.phase = grf_apb_done_type_e;
                    if (pwrite) begin
                        st_d.pslverr = 1'b0;
                    end
                end else begin
                    st_d.prdata = '0;
                    // error is held back so that it leaves together with ready
                    st_d.err = pwrite;
                    st_d.phase = grf_apb_done_type_e;
                end
            end
            grf_apb_wr2_type_e: begin
                // waits for a free port: a core write steals the cycle
                if (!core_we) begin
                    mif.we = 1'b1;
                    mif.waddr = maddr(st_q.hi_bank, st_q.hi_sel);
                    mif.wdata = st_q.apb_wr[15:0];
                    mif.wbe = 2'h3;
                    st_d.phase = grf_apb_done_type_e;
                end
            end
            grf_apb_done_type_e: begin
                st_d.pready = 1'b1;
                st_d.pslverr = st_q.err;
                st_d.phase = grf_idle_type_e;
            end
            default: st_d.phase = grf_idle_type_e;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        core_rvalid = st_q.core_rvalid;
        core_rdata = st_q.core_rdata;
        core_base = st_q.core_base;
        bank_sel = st_q.bank;
        prdata = st_q.prdata;
        pready = st_q.pready;
        pslverr = st_q.pslverr;
    end
endmodule

// *** tb/grf_top_monitor.sv ***
// checker: port-level assertions of the register file
module grf_top_monitor (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic core_re,
    input wire logic core_rvalid,
    input wire logic core_base_sel,
    input wire logic core_base_long,
    input wire logic [31:0] core_base,
    input wire logic core_bank_set,
    input wire logic core_bank_val,
    input wire logic bank_sel,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence bank_cmd_s;
        core_bank_set ##1 1'b1;
    endsequence
    rd_lat_a: assert property (core_rvalid |-> $past(core_re, 2))
        else $error("read answer late");
    rd_pulse_a: assert property (core_rvalid |=> !core_rvalid)
        else $error("read valid too long");
    bank_take_a: assert property (bank_cmd_s |-> bank_sel == $past(core_bank_val))
        else $error("bank not taken");
    // apb may move the bank too, so both causes are allowed
    bank_keep_a: assert property ($changed(bank_sel) |->
        $past(core_bank_set) || $past(psel))
        else $error("bank moved alone");
    base_lat_a: assert property ($changed(core_base) |->
        $past(core_base_sel, 2) || $past(core_base_long, 2))
        else $error("base moved alone");
    rdy_phase_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("ready too long");
    err_rdy_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule
bind grf_top grf_top_monitor u_grf_top_monitor (.*);

// *** tb/grf_core.sv ***
// model: core datapath issuing register file requests
module grf_core (
    input wire logic sys_clk,
    input wire logic core_rvalid,
    output logic core_we,
    output logic [2:0] core_wsel,
    output logic [1:0] core_wsize,
    output logic core_whigh,
    output logic [31:0] core_wdata,
    output logic core_re,
    output logic [2:0] core_rsel,
    output logic [1:0] core_rsize,
    output logic core_rhigh,
    output logic core_base_sel,
    output logic core_base_long,
    output logic core_bank_set,
    output logic core_bank_val
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {core_we, core_wsel, core_wsize, core_whigh, core_wdata} = 0;
    initial {core_re, core_rsel, core_rsize, core_rhigh} = 0;
    initial {core_base_sel, core_base_long, core_bank_set, core_bank_val} = 0;
    // write enable stays up so back-to-back writes land on every edge
    task automatic wr(input logic [2:0] s, input logic [1:0] z, input logic h,
                      input logic [15:0] d);
        core_we <= 1'b1;
        core_wsel <= s;
        core_wsize <= z;
        core_whigh <= h;
        core_wdata <= {16'hFFFF, d};
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [2:0] s, input logic [1:0] z, input logic h);
        core_we <= 1'b0;
        core_re <= 1'b1;
        core_rsel <= s;
        core_rsize <= z;
        core_rhigh <= h;
        @(posedge sys_clk);
        core_re <= 1'b0;
        // this wait ends once core_rvalid is seen high, or else at the bench watchdog
        do @(posedge sys_clk); while (core_rvalid !== 1'b1);
    endtask
    // {bank set, bank value, base select, base long}
    task automatic side(input logic [3:0] c);
        core_we <= 1'b0;
        {core_bank_set, core_bank_val, core_base_sel, core_base_long} <= c;
        @(posedge sys_clk);
        core_bank_set <= 1'b0;
        {core_base_sel, core_base_long} <= 2'h0;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule

// *** tb/grf_top_test.sv ***
// testbench: register file under a core model and an apb master
module grf_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic core_we, core_whigh, core_re, core_rhigh, core_rvalid, pready, pslverr;
    logic core_base_sel, core_base_long, core_bank_set, core_bank_val, bank_sel;
    logic [2:0] core_wsel, core_rsel;
    logic [1:0] core_wsize, core_rsize;
    logic [31:0] core_wdata, core_rdata, core_base, prdata;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, seed = 32'h0001_2D83;
    logic [15:0] m [2][7];
    logic [32:0] cq[$], aq[$], apb_seen;
    int failures = 0, samples_checked = 0;
    grf_top u_grf_top (.*);
    grf_core u_grf_core (.*);
    assign apb_seen = {pslverr, pwrite ? 32'h0 : prdata};
    always #10 sys_clk = ~sys_clk;
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic check(input string n, input logic [32:0] s, input logic [32:0] e);
        samples_checked++;
        if (s !== e) failures++;
        if (s !== e) $display("BAD %s expected %h seen %h", n, e, s);
    endtask
    task automatic wrap_up();
        if (cq.size() != 0 || aq.size() != 0) failures++;
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(negedge sys_clk) begin
        if (core_rvalid === 1'b1) check("rdata", {1'b0, core_rdata}, cq.pop_front());
        if (pready === 1'b1) check("apb", apb_seen, aq.pop_front());
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        aq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic cr(input logic [2:0] s, input logic [1:0] z, input logic [31:0] e,
                      input logic h = 1'b0);
        cq.push_back({1'b0, e});
        u_grf_core.rd(s, z, h);
    endtask
    initial begin
        #40000;
        failures++;
        wrap_up();
    end
    initial begin
        logic [15:0] v;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 14; i++) begin
            if (i == 7) u_grf_core.side(4'hC);
            v = rnd();
            m[i / 7][i % 7] = v;
            u_grf_core.wr(3'(i % 7), 2'h1, 1'b0, v);
        end
        u_grf_core.side(4'h8);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            u_grf_core.wr(3'(i / 2), 2'h0, i[0], v);
            if (i[0]) m[0][i / 2][15:8] = v[7:0];
            else m[0][i / 2][7:0] = v[7:0];
        end
        cr(3'h0, 2'h0, {24'h0, m[0][0][15:8]}, 1'b1);
        cr(3'h1, 2'h0, {24'h0, m[0][1][7:0]});
        for (int i = 0; i < 7; i++) begin
            cr(3'(i), 2'h1, {16'h0, m[0][i]});
            apb(1'b0, 8'(8'h20 + 4 * i), 32'h0, {17'h0, m[1][i]});
        end
        cr(3'h0, 2'h2, {m[0][2], m[0][0]});
        cr(3'h1, 2'h2, {m[0][3], m[0][1]});
        cr(3'h4, 2'h2, {m[0][5], m[0][4]});
        u_grf_core.side(4'h1);
        check("base", {1'b0, core_base}, {1'b0, m[0][5], m[0][4]});
        u_grf_core.side(4'h2);
        check("base", {1'b0, core_base}, {17'h0, m[0][5]});
        v = rnd();
        m[1][3] = v;
        apb(1'b1, 8'h2C, {16'h0, v}, 33'h0);
        apb(1'b1, grf_pkg::grf_apb_ctrl, 32'h1, 33'h0);
        apb(1'b0, grf_pkg::grf_apb_ctrl, 32'h0, 33'h1);
        apb(1'b1, 8'h50, 32'h5, 33'h1_0000_0000);
        cr(3'h3, 2'h1, {16'h0, v});
        apb(1'b0, 8'h0C, 32'h0, {17'h0, m[0][3]});
        apb(1'b0, grf_pkg::grf_apb_data_pair, 32'h0, {1'b0, m[1][2], 16'h0});
        apb(1'b0, grf_pkg::grf_apb_addr_pair, 32'h0, {1'b0, m[1][5], 16'h0});
        apb(1'b0, grf_pkg::grf_apb_data1_pair, 32'h0, {1'b0, m[1][3], 16'h0});
        check("bank", {32'h0, bank_sel}, 33'h1);
        repeat (3) @(posedge sys_clk);
        wrap_up();
    end
endmodule
